// ### core/rxf_pkg.sv
// constants shared by the receive filter and status block
package rxf_pkg;

    // register word offsets on the plain register port
    localparam logic [5:0] OFS_FILTER_STATUS = 6'h02;
    localparam logic [5:0] OFS_TABLE_SEL = 6'h20;
    localparam logic [5:0] OFS_TABLE_W0 = 6'h21;
    localparam logic [5:0] OFS_TABLE_W1 = 6'h22;
    localparam logic [5:0] OFS_TABLE_W2 = 6'h23;
    localparam logic [5:0] OFS_TABLE_EN = 6'h24;

    // field positions of receive_filter_and_status
    localparam int B_ACCEPT_ERRORS = 15;
    localparam int B_ACCEPT_SHORT_FRAMES = 14;
    localparam int B_ACCEPT_BROADCAST = 13;
    localparam int B_ACCEPT_ALL_INDIVIDUAL = 12;
    localparam int B_ACCEPT_ALL_GROUP = 11;
    localparam int B_LOOPBACK_SEL_HI = 10;
    localparam int B_LOOPBACK_SEL_LO = 9;
    localparam int B_GROUP_FRAME_SEEN = 8;
    localparam int B_ALL_ONES_FRAME_SEEN = 7;
    localparam int B_FINAL_FRAME_IN_AREA = 6;
    localparam int B_CARRIER_ACTIVITY = 5;
    localparam int B_COLLISION_ACTIVITY = 4;
    localparam int B_CHECKSUM_ERROR = 3;
    localparam int B_ALIGNMENT_ERROR = 2;
    localparam int B_LOOPED_FRAME_SEEN = 1;
    localparam int B_FRAME_RECEIVED_GOOD = 0;

    // reset value and masks
    localparam logic [15:0] FILTER_STATUS_RST = 16'h0000;
    localparam logic [15:0] CTRL_WRITE_MASK = 16'hFE00;
    localparam logic [15:0] FRAME_START_CLEAR = 16'h01CF;
    localparam logic [15:0] TABLE_EN_RST = 16'h0000;

    // loopback mode encodings
    localparam logic [1:0] LOOPBACK_OFF = 2'h0;

    // address width and first-octet group bit position
    localparam int ADDR_W = 48;
    localparam int GROUP_BIT = 40;

endpackage

// ### core/rxf_addr_class.sv
// destination address classifier: broadcast and group, registered
module rxf_addr_class (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic da_valid_i,
    input wire logic [rxf_pkg::ADDR_W-1:0] da_i,
    output logic class_valid_o,
    output logic all_ones_o,
    output logic group_o
);

    typedef struct packed {
        logic valid;
        logic all_ones;
        logic group;
    } rxf_cls_t;

    rxf_cls_t s;
    rxf_cls_t next_s;

    // broadcast is all ones; group is the i/g bit of the first octet
    always_comb begin
        next_s = s;
        next_s.valid = da_valid_i;
        if (da_valid_i) begin
            next_s.all_ones = &da_i;
            next_s.group = da_i[rxf_pkg::GROUP_BIT];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign class_valid_o = s.valid;
    assign all_ones_o = s.all_ones;
    assign group_o = s.group;

endmodule

// ### core/rxf_station_table.sv
// station address table: entries, per-entry enable, registered match
module rxf_station_table #(
    parameter int DEPTH = 16,
    parameter int IDX_W = 4
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic wr_i,
    input wire logic [IDX_W-1:0] wr_idx_i,
    input wire logic [rxf_pkg::ADDR_W-1:0] wr_data_i,
    input wire logic [DEPTH-1:0] entry_en_i,
    input wire logic lookup_i,
    input wire logic [rxf_pkg::ADDR_W-1:0] key_i,
    output logic hit_valid_o,
    output logic hit_o
);

    typedef struct packed {
        logic [DEPTH-1:0][rxf_pkg::ADDR_W-1:0] mem;
        logic valid;
        logic hit;
    } rxf_tbl_t;

    rxf_tbl_t s;
    rxf_tbl_t next_s;

    // compare all enabled entries in parallel; result one cycle later
    always_comb begin
        next_s = s;
        next_s.valid = lookup_i;
        next_s.hit = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            if (entry_en_i[i] && s.mem[i] == key_i) begin
                next_s.hit = lookup_i;
            end
        end
        if (wr_i) begin
            next_s.mem[wr_idx_i] = wr_data_i;
        end
    end

    // contents survive reset on purpose; only the entry enables gate them
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s.valid <= 1'b0;
            s.hit <= 1'b0;
            s.mem <= next_s.mem;
        end else begin
            s <= next_s;
        end
    end

    assign hit_valid_o = s.valid;
    assign hit_o = s.hit;

endmodule

// ### core/rxf_filter.sv
// receive acceptance filter and per-frame status register
//
// What this block does
// - upper five control bits each enable a filter
// - no filter bits: accept table matches only
// - two-bit loopback field selects loopback mode
// - nine status bits set per frame condition
// - accepted frame copies whole register to descriptor
// - next frame start clears bits 8-6, 3-0
// - software reset leaves register unchanged
// - error bit: accept crc errors and collisions
// - short-frame bit accepts frames under 64 bytes
// - hardware reset clears short-frame bit
// - broadcast bit accepts broadcast frames too
// - hardware reset clears broadcast bit
// - promiscuous bit accepts all individual addresses
// - all-group bit accepts every multicast frame
// - all-group bit also accepts broadcast frames
// - bit 8 multicast, bit 7 broadcast
// - bit 6 when remaining words within threshold
// - alignment error only with crc, replaces it
// - bit 0 when frame free of errors
module rxf_filter #(
    parameter int TABLE_DEPTH = 16,
    parameter int TABLE_IDX_W = 4,
    parameter int WORDS_W = 16
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic sw_reset_i,
    // register port
    input wire logic [5:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // mac receive side
    input wire logic rx_start_i,
    input wire logic rx_da_valid_i,
    input wire logic [rxf_pkg::ADDR_W-1:0] rx_da_i,
    input wire logic rx_end_i,
    input wire logic rx_crc_err_i,
    input wire logic rx_align_err_i,
    input wire logic rx_collision_i,
    input wire logic rx_short_i,
    input wire logic carrier_activity_i,
    input wire logic [WORDS_W-1:0] remaining_buffer_words_i,
    input wire logic [WORDS_W-1:0] end_of_buffer_threshold_i,
    // results
    output logic rx_accept_o,
    output logic rx_reject_o,
    output logic rx_descriptor_valid_o,
    output logic [15:0] rx_descriptor_status_word_o,
    output logic [1:0] loopback_sel_o
);

    typedef enum logic [0:0] {
        RXF_IDLE,
        RXF_FRAME
    } rxf_state_t;

    typedef struct packed {
        rxf_state_t fsm;
        logic [15:0] receive_filter_and_status;
        logic [15:0] rdata;
        logic [15:0] desc;
        logic desc_valid;
        logic accept;
        logic reject;
        logic [TABLE_IDX_W-1:0] sel;
        logic [15:0] w0;
        logic [15:0] w1;
        logic [TABLE_DEPTH-1:0] en;
        logic hit;
        logic all_ones;
        logic group;
        logic crs_seen;
    } rxf_regs_t;

    rxf_regs_t s;
    rxf_regs_t next_s;

    logic tbl_wr;
    logic hit_valid;
    logic hit;
    logic class_valid;
    logic all_ones;
    logic group;
    logic addr_ok;
    logic err_ok;
    logic len_ok;
    logic frame_ok;
    logic looped;
    logic [15:0] status_word;

    // read mux shared by the register port
    function automatic logic [15:0] read_mux(input rxf_regs_t r, input logic [5:0] a);
        logic [15:0] d;
        d = 16'h0000;
        case (a)
            rxf_pkg::OFS_FILTER_STATUS: d = r.receive_filter_and_status;
            rxf_pkg::OFS_TABLE_SEL: d = 16'(r.sel);
            rxf_pkg::OFS_TABLE_W0: d = r.w0;
            rxf_pkg::OFS_TABLE_W1: d = r.w1;
            rxf_pkg::OFS_TABLE_EN: d = 16'(r.en);
            default: d = 16'h0000;
        endcase
        return d;
    endfunction

    // the table entry is committed when its top word is written
    assign tbl_wr = reg_wr_i && reg_addr_i == rxf_pkg::OFS_TABLE_W2;

    rxf_station_table #(
        .DEPTH(TABLE_DEPTH),
        .IDX_W(TABLE_IDX_W)
    ) u_table (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .wr_i(tbl_wr),
        .wr_idx_i(s.sel),
        .wr_data_i({reg_wdata_i, s.w1, s.w0}),
        .entry_en_i(s.en),
        .lookup_i(rx_da_valid_i),
        .key_i(rx_da_i),
        .hit_valid_o(hit_valid),
        .hit_o(hit)
    );

    rxf_addr_class u_class (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .da_valid_i(rx_da_valid_i),
        .da_i(rx_da_i),
        .class_valid_o(class_valid),
        .all_ones_o(all_ones),
        .group_o(group)
    );

    // acceptance: address filters, then error and length gates
    always_comb begin
        addr_ok = s.hit;
        if (s.receive_filter_and_status[rxf_pkg::B_ACCEPT_BROADCAST] && s.all_ones) begin
            addr_ok = 1'b1;
        end
        if (s.receive_filter_and_status[rxf_pkg::B_ACCEPT_ALL_GROUP] && s.group) begin
            addr_ok = 1'b1;
        end
        if (s.receive_filter_and_status[rxf_pkg::B_ACCEPT_ALL_INDIVIDUAL] && !s.group) begin
            addr_ok = 1'b1;
        end
        // error gate: the error bit lets crc errors and collisions through, each on its own
        err_ok = s.receive_filter_and_status[rxf_pkg::B_ACCEPT_ERRORS]
            || !(rx_crc_err_i || rx_collision_i);
        len_ok = s.receive_filter_and_status[rxf_pkg::B_ACCEPT_SHORT_FRAMES] || !rx_short_i;
        frame_ok = addr_ok && err_ok && len_ok;
    end

    // per-frame status bits, built from the frame that just ended
    always_comb begin
        looped = s.receive_filter_and_status[rxf_pkg::B_LOOPBACK_SEL_HI:rxf_pkg::B_LOOPBACK_SEL_LO]
            != rxf_pkg::LOOPBACK_OFF;
        status_word = s.receive_filter_and_status;
        status_word[rxf_pkg::B_GROUP_FRAME_SEEN] = s.group;
        status_word[rxf_pkg::B_ALL_ONES_FRAME_SEEN] = s.all_ones;
        status_word[rxf_pkg::B_FINAL_FRAME_IN_AREA] =
            remaining_buffer_words_i <= end_of_buffer_threshold_i;
        status_word[rxf_pkg::B_CARRIER_ACTIVITY] = s.crs_seen || carrier_activity_i;
        status_word[rxf_pkg::B_COLLISION_ACTIVITY] = rx_collision_i;
        status_word[rxf_pkg::B_CHECKSUM_ERROR] = rx_crc_err_i && !rx_align_err_i;
        status_word[rxf_pkg::B_ALIGNMENT_ERROR] = rx_crc_err_i && rx_align_err_i;
        status_word[rxf_pkg::B_FRAME_RECEIVED_GOOD] = !rx_crc_err_i && !rx_align_err_i
            && !rx_short_i && !rx_collision_i;
        // a looped frame counts only when it arrived clean
        status_word[rxf_pkg::B_LOOPED_FRAME_SEEN] = looped
            && status_word[rxf_pkg::B_FRAME_RECEIVED_GOOD];
    end

    // next state: frame sequencing, register port, descriptor word
    always_comb begin
        next_s = s;
        next_s.desc_valid = 1'b0;
        next_s.accept = 1'b0;
        next_s.reject = 1'b0;
        next_s.rdata = 16'h0000;

        // lookup results arrive one cycle after the destination address
        if (hit_valid) begin
            next_s.hit = hit;
        end
        if (class_valid) begin
            next_s.all_ones = all_ones;
            next_s.group = group;
        end

        case (s.fsm)
            RXF_IDLE: begin
                if (rx_start_i) begin
                    next_s.fsm = RXF_FRAME;
                    next_s.receive_filter_and_status = s.receive_filter_and_status & ~rxf_pkg::FRAME_START_CLEAR;
                    next_s.hit = 1'b0;
                    next_s.all_ones = 1'b0;
                    next_s.group = 1'b0;
                    next_s.crs_seen = carrier_activity_i;
                end
            end
            RXF_FRAME: begin
                if (carrier_activity_i) begin
                    next_s.crs_seen = 1'b1;
                end
                if (rx_end_i) begin
                    next_s.fsm = RXF_IDLE;
                    // status is latched for every frame; only accepted ones are copied
                    next_s.receive_filter_and_status = status_word;
                    next_s.accept = frame_ok;
                    next_s.reject = !frame_ok;
                    if (frame_ok) begin
                        next_s.desc = status_word;
                        next_s.desc_valid = 1'b1;
                    end
                end
            end
            default: begin
                next_s.fsm = RXF_IDLE;
            end
        endcase

        // software reset aborts a frame but keeps every register bit
        if (sw_reset_i) begin
            next_s.fsm = RXF_IDLE;
            next_s.accept = 1'b0;
            next_s.reject = 1'b0;
            next_s.desc_valid = 1'b0;
        end

        // register writes touch control bits only; status stays read-only
        if (reg_wr_i) begin
            case (reg_addr_i)
                rxf_pkg::OFS_FILTER_STATUS: begin
                    next_s.receive_filter_and_status = (next_s.receive_filter_and_status & ~rxf_pkg::CTRL_WRITE_MASK)
                        | (reg_wdata_i & rxf_pkg::CTRL_WRITE_MASK);
                end
                rxf_pkg::OFS_TABLE_SEL: next_s.sel = reg_wdata_i[TABLE_IDX_W-1:0];
                rxf_pkg::OFS_TABLE_W0: next_s.w0 = reg_wdata_i;
                rxf_pkg::OFS_TABLE_W1: next_s.w1 = reg_wdata_i;
                rxf_pkg::OFS_TABLE_EN: next_s.en = reg_wdata_i[TABLE_DEPTH-1:0];
                default: begin
                end
            endcase
        end

        // read data stand only in the cycle after the strobe
        if (reg_rd_i) begin
            next_s.rdata = read_mux(s, reg_addr_i);
        end
    end

    // hardware reset clears the whole register, short and broadcast bits included
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s <= '0;
            s.fsm <= RXF_IDLE;
            s.receive_filter_and_status <= rxf_pkg::FILTER_STATUS_RST;
            s.en <= TABLE_DEPTH'(rxf_pkg::TABLE_EN_RST);
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from state
    assign reg_rdata_o = s.rdata;
    assign rx_accept_o = s.accept;
    assign rx_reject_o = s.reject;
    assign rx_descriptor_valid_o = s.desc_valid;
    assign rx_descriptor_status_word_o = s.desc;
    assign loopback_sel_o = s.receive_filter_and_status[rxf_pkg::B_LOOPBACK_SEL_HI:rxf_pkg::B_LOOPBACK_SEL_LO];

endmodule

// ### verification/rxf_filter_properties.sv
// assertion checker for the receive filter, bound to its top module
module rxf_filter_checker #(
    parameter int WORDS_W = 16
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic rx_end_i,
    input wire logic rx_crc_err_i,
    input wire logic rx_align_err_i,
    input wire logic rx_collision_i,
    input wire logic rx_short_i,
    input wire logic [WORDS_W-1:0] remaining_buffer_words_i,
    input wire logic [WORDS_W-1:0] end_of_buffer_threshold_i,
    input wire logic rx_accept_o,
    input wire logic rx_reject_o,
    input wire logic rx_descriptor_valid_o,
    input wire logic [15:0] rx_descriptor_status_word_o,
    input wire logic [1:0] loopback_sel_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // short alias for the descriptor word
    wire [15:0] dw = rx_descriptor_status_word_o;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (srst_i);

    a_one_verdict: assert property (!(rx_accept_o && rx_reject_o))
        else $error("accept and reject together");
    a_verdict_after_end: assert property ((rx_accept_o || rx_reject_o) |-> $past(rx_end_i))
        else $error("verdict without frame end");
    a_desc_with_accept: assert property (rx_descriptor_valid_o == rx_accept_o)
        else $error("descriptor not paired with accept");
    a_checksum_split: assert property (rx_descriptor_valid_o |-> dw[3:2] ==
        {$past(rx_crc_err_i && !rx_align_err_i), $past(rx_crc_err_i && rx_align_err_i)})
        else $error("crc and alignment bits wrong");
    a_good_flag: assert property (rx_descriptor_valid_o |-> dw[0] ==
        $past(!(rx_crc_err_i || rx_align_err_i || rx_collision_i || rx_short_i)))
        else $error("good frame bit wrong");
    a_error_gate: assert property (rx_descriptor_valid_o && !dw[15] |-> dw[4:2] == 3'h0)
        else $error("errored frame accepted");
    a_short_gate: assert property (rx_descriptor_valid_o && !dw[14] |-> !$past(rx_short_i))
        else $error("short frame accepted");
    a_bcast_is_group: assert property (rx_descriptor_valid_o && dw[7] |-> dw[8])
        else $error("broadcast without group bit");
    a_area_final: assert property (rx_descriptor_valid_o |-> dw[6] ==
        $past(remaining_buffer_words_i <= end_of_buffer_threshold_i))
        else $error("final frame bit wrong");
    a_loopback_write: assert property (reg_wr_i && reg_addr_i == rxf_pkg::OFS_FILTER_STATUS
        |=> loopback_sel_o == $past(reg_wdata_i[10:9]))
        else $error("loopback field not written");
    a_reset_clear: assert property ($past(srst_i) |-> dw == 16'h0000 && loopback_sel_o == 2'h0)
        else $error("outputs not cleared by reset");
endmodule

bind rxf_filter rxf_filter_checker #(.WORDS_W(WORDS_W)) rxf_filter_checker_inst (.*);

// ### verification/rxf_mac_model.sv
// behavioural model of the mac receive section feeding the filter
module rxf_mac_model (
    input wire logic clk_sys_i,
    output logic rx_start_o,
    output logic rx_da_valid_o,
    output logic [47:0] rx_da_o,
    output logic rx_end_o,
    output logic [3:0] rx_err_o,
    output logic carrier_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle link at time zero
    initial begin
        {rx_start_o, rx_da_valid_o, rx_end_o, carrier_o} = 4'h0;
        rx_da_o = 48'h000000000000;
        rx_err_o = 4'h0;
    end
    // start pulse, then the address one cycle later; carrier held through the frame
    task automatic begin_frame(input logic [47:0] da, input logic carrier_activity);
        @(posedge clk_sys_i);
        rx_start_o <= 1'b1;
        carrier_o <= carrier_activity;
        @(posedge clk_sys_i);
        rx_start_o <= 1'b0;
        rx_da_valid_o <= 1'b1;
        rx_da_o <= da;
        @(posedge clk_sys_i);
        rx_da_valid_o <= 1'b0;
        rx_da_o <= ~da; // released bus has no pull: show the inverse
    endtask
    // end pulse with its qualifiers {short, collision, align, crc}, two cycles of gap first
    task automatic end_frame(input logic [3:0] err);
        repeat (2) @(posedge clk_sys_i);
        rx_end_o <= 1'b1;
        rx_err_o <= err;
        @(posedge clk_sys_i);
        rx_end_o <= 1'b0;
        rx_err_o <= 4'h0;
        carrier_o <= 1'b0;
    endtask
endmodule

// ### verification/rxf_filter_tb.sv
// self-checking testbench for the receive filter and status block
module rxf_filter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // one row: control word, address, {carrier, short, collision, align, crc}, accepted
    typedef struct packed {
        logic [15:0] ctrl;
        logic [47:0] da;
        logic [4:0] fl;
        logic acc;
    } rxf_row_t;
    localparam logic [47:0] DA_STN = 48'h021122334455;
    localparam logic [47:0] DA_ALL = 48'hFFFFFFFFFFFF;
    localparam logic [47:0] DA_GRP = 48'h01005E000001;
    localparam logic [47:0] DA_OTH = 48'h0A0000000001;
    localparam logic [5:0] OFS = rxf_pkg::OFS_FILTER_STATUS;
    localparam rxf_row_t ROWS [18] = '{
        '{16'h0000, DA_STN, 5'h00, 1'b1}, '{16'h0000, DA_OTH, 5'h00, 1'b0},
        '{16'h0000, DA_ALL, 5'h00, 1'b0}, '{16'h2000, DA_ALL, 5'h00, 1'b1},
        '{16'h2000, DA_STN, 5'h00, 1'b1}, '{16'h0800, DA_ALL, 5'h00, 1'b1},
        '{16'h0800, DA_GRP, 5'h00, 1'b1}, '{16'h1000, DA_OTH, 5'h00, 1'b1},
        '{16'h1000, DA_GRP, 5'h00, 1'b0}, '{16'h0000, DA_STN, 5'h01, 1'b0},
        '{16'h8000, DA_STN, 5'h03, 1'b1}, '{16'h0000, DA_STN, 5'h04, 1'b0},
        '{16'h8000, DA_STN, 5'h14, 1'b1}, '{16'h0000, DA_STN, 5'h08, 1'b0},
        '{16'h4000, DA_STN, 5'h08, 1'b1}, '{16'h0200, DA_STN, 5'h00, 1'b1},
        '{16'h0400, DA_STN, 5'h10, 1'b1}, '{16'h0600, DA_STN, 5'h02, 1'b1}};
    logic clk_sys_i, srst_i, sw_reset_i, reg_wr_i, reg_rd_i;
    logic rx_start_i, rx_da_valid_i, rx_end_i, carrier_activity_i;
    logic rx_crc_err_i, rx_align_err_i, rx_collision_i, rx_short_i;
    logic rx_accept_o, rx_reject_o, rx_descriptor_valid_o;
    logic [1:0] loopback_sel_o;
    logic [5:0] reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, rx_descriptor_status_word_o, got, prev;
    logic [15:0] remaining_buffer_words_i, end_of_buffer_threshold_i;
    logic [47:0] rx_da_i;
    int err_total = 0;
    int compares = 0;

    rxf_filter rxf_filter_inst (.*);
    rxf_mac_model rxf_mac_model_inst (.clk_sys_i(clk_sys_i), .rx_start_o(rx_start_i),
        .rx_da_valid_o(rx_da_valid_i), .rx_da_o(rx_da_i), .rx_end_o(rx_end_i),
        .rx_err_o({rx_short_i, rx_collision_i, rx_align_err_i, rx_crc_err_i}),
        .carrier_o(carrier_activity_i));

    // 125 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    // expected register word; the final-area bit uses the row index against a threshold of 6
    function automatic logic [15:0] exp_word(input rxf_row_t r, input logic [15:0] idx);
        logic good;
        good = !(|r.fl[3:0]);
        return {r.ctrl[15:9], r.da[40], &r.da, idx <= 16'h0006, r.fl[4], r.fl[2],
            r.fl[0] & !r.fl[1], r.fl[0] & r.fl[1], good & (r.ctrl[10:9] != 2'h0), good};
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask
    task automatic test_done(input string s);
        $display("test %s done", s);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        #400000;
        err_total++;
        end_of_test;
    end
    // main sequence
    initial begin
        {srst_i, sw_reset_i, reg_wr_i, reg_rd_i} = 4'h8;
        reg_addr_i = 6'h00;
        reg_wdata_i = 16'h0000;
        remaining_buffer_words_i = 16'h0000;
        end_of_buffer_threshold_i = 16'h0006;
        repeat (20) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        wr(rxf_pkg::OFS_TABLE_SEL, 16'h0000);
        wr(rxf_pkg::OFS_TABLE_W0, DA_STN[15:0]);
        wr(rxf_pkg::OFS_TABLE_W1, DA_STN[31:16]);
        wr(rxf_pkg::OFS_TABLE_W2, DA_STN[47:32]);
        wr(rxf_pkg::OFS_TABLE_EN, 16'h0001);
        for (int i = 0; i < 18; i++) begin
            wr(OFS, ROWS[i].ctrl);
            remaining_buffer_words_i <= i[15:0];
            rxf_mac_model_inst.begin_frame(ROWS[i].da, ROWS[i].fl[4]);
            rxf_mac_model_inst.end_frame(ROWS[i].fl[3:0]);
            #1;
            chk({11'h0, loopback_sel_o, rx_descriptor_valid_o, rx_accept_o, rx_reject_o},
                {11'h0, ROWS[i].ctrl[10:9], ROWS[i].acc, ROWS[i].acc, !ROWS[i].acc});
            if (ROWS[i].acc) chk(rx_descriptor_status_word_o, exp_word(ROWS[i], i[15:0]));
            rd(OFS, got);
            chk(got, exp_word(ROWS[i], i[15:0]));
        end
        test_done("filter rows");
        // load bits 8-3 first (alignment, looped and good stay clear), so that the start clear has something to drop
        @(posedge clk_sys_i);
        remaining_buffer_words_i <= 16'h0000;
        rxf_mac_model_inst.begin_frame(DA_ALL, 1'b1);
        rxf_mac_model_inst.end_frame(4'h5);
        rd(OFS, prev);
        chk(prev, 16'h07F8);
        // a new frame start clears the per-frame bits but not carrier and collision
        rxf_mac_model_inst.begin_frame(DA_OTH, 1'b0);
        rd(OFS, got);
        chk(got, 16'h0630);
        rxf_mac_model_inst.end_frame(4'h0);
        test_done("start clear");
        rd(OFS, prev);
        wr(OFS, 16'hFFFF);
        rd(OFS, got);
        chk(got, {7'h7F, prev[8:0]});
        @(posedge clk_sys_i);
        sw_reset_i <= 1'b1;
        @(posedge clk_sys_i);
        sw_reset_i <= 1'b0;
        rd(OFS, got);
        chk(got, {7'h7F, prev[8:0]});
        rd(6'h3F, got);
        chk(got, 16'h0000);
        test_done("write mask and soft reset");
        @(posedge clk_sys_i);
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        rd(OFS, got);
        chk(got, 16'h0000);
        test_done("hardware reset");
        end_of_test;
    end
endmodule
